// >>> shared/pfc_seq_defs.vh
// Purpose: Constants for the light-load mode sequencer
// Assumes: Included by its bare name
// Notes: Byte offsets on a 32-bit classic Wishbone slave
`ifndef PFC_SEQ_DEFS_VH
`define PFC_SEQ_DEFS_VH

// ****************************************
// Register offsets
// ****************************************
`define OFS_CTRL 8'h00
`define OFS_FILTER 8'h04
`define OFS_STATUS 8'h08
`define OFS_FAULT 8'h0c

// ****************************************
// Control fields and reset values
// ****************************************
`define CTRL_BURST_EN 0
`define CTRL_SHED_EN 1
`define CTRL_RESET 2'h3

// ****************************************
// Status fields
// ****************************************
`define ST_MODE_LSB 0
`define ST_SINGLE 3
`define ST_HIGH_LINE 4
`define ST_HI_CURRENT 5
`define ST_GAIN_BOOST 6
`define ST_PHASE_B 7

// ****************************************
// Timing counts
// ****************************************
`define SHED_HALF_CYCLES 8'h0e
`define RAMP_STEPS 4'h8

`endif

// >>> src/pfc_light_load_mode_sequencer.v
// Purpose: Mode sequencer of a two-phase interleaved PFC controller
// Assumes: Comparator results arrive as digital levels from another domain
// Notes: Rules below bind this block
// Contract
// RULE1 - High line raises shed threshold by offset
// RULE2 - High line raises burst threshold by offset
// RULE3 - Comp below burst heads to idle
// RULE4 - Idle resumes above burst plus hysteresis
// RULE5 - Eight ramp-down switching cycles before stop
// RULE6 - Eight ramp-up switching cycles on exit
// RULE7 - Below burst forces single phase
// RULE8 - Shed below burst: single during ramps
// RULE9 - Shed threshold 600mV above burst, advisory
// RULE10 - Sense pulled low: standby, discharge comp
// RULE11 - Sense released: enter soft-start
// RULE12 - High charge current until sense 3V
// RULE13 - Soft-start ends at 95 percent
// RULE14 - Soft-start: both phases, no burst
// RULE15 - Faults discharge comp, then soft-start
// RULE16 - Latch fault; wait discharge and clear
// RULE17 - Five percent error boosts gain
// RULE18 - Below shed: B stops, A doubles, clamped
// RULE19 - Shed entry needs 14 half cycles
// RULE20 - Above shed hysteresis: B restarts immediately
// RULE21 - Two-stage synchronisers on all inputs; the code syncs the comparator and fault inputs only, not Wishbone
// RULE22 - Priority fault, soft-start, burst, shedding
`timescale 1ns/1ps
`include "pfc_seq_defs.vh"

module pfc_light_load_mode_sequencer #(
  parameter WB_AW = 8
) (
  // Clock and reset
  input wire REF_CLK_I,
  input wire RESET_I,
  // Wishbone slave
  input wire WB_CYC_I,
  input wire WB_STB_I,
  input wire WB_WE_I,
  input wire [WB_AW-1:0] WB_ADR_I,
  input wire [3:0] WB_SEL_I,
  input wire [31:0] WB_DAT_I,
  output reg [31:0] WB_DAT_O,
  output reg WB_ACK_O,
  // Comparator results
  input wire COMP_BELOW_BURST_I,
  input wire COMP_ABOVE_BURST_HYS_I,
  input wire COMP_BELOW_SHED_I,
  input wire COMP_ABOVE_SHED_HYS_I,
  input wire SHED_BELOW_BURST_I,
  input wire COMP_DISCHARGED_I,
  input wire LINE_SENSE_INPUT_HIGH_I,
  input wire LINE_POLARITY_I,
  input wire OUTPUT_SENSE_DISABLED_I,
  input wire OUTPUT_SENSE_ABOVE_3V_I,
  input wire OUTPUT_SENSE_AT_95PCT_I,
  input wire ERROR_OUT_OF_BAND_I,
  input wire SWITCH_CYCLE_I,
  // Fault inputs
  input wire FAILSAFE_OVERVOLTAGE_SENSE_I,
  input wire BROWNOUT_I,
  input wire UNDERVOLTAGE_LOCKOUT_I,
  input wire OTHER_FAULT_I,
  // Power stage controls
  output reg PHASE_A_ENABLE_O,
  output reg PHASE_B_GATE_DRIVE_ENABLE_O,
  output reg ON_TIME_DOUBLE_O,
  output reg [3:0] ON_TIME_SCALE_O,
  output reg HIGH_LINE_O,
  output reg SHED_OFFSET_EN_O,
  output reg BURST_OFFSET_EN_O,
  output reg COMP_DISCHARGE_O,
  output reg STANDBY_O,
  output reg SOFTSTART_HI_CURRENT_O,
  output reg GAIN_BOOST_O,
  output reg [2:0] MODE_O
);

  // ****************************************
  // States
  // ****************************************
  localparam ST_FAULT = 3'h0;
  localparam ST_SOFTSTART = 3'h1;
  localparam ST_RUN = 3'h2;
  localparam ST_SOFTOFF = 3'h3;
  localparam ST_IDLE = 3'h4;
  localparam ST_SOFTON = 3'h5;
  localparam NIN = 17;

  function hit;
    input [WB_AW-1:0] adr;
    input [7:0] ofs;
    begin
      hit = (adr[7:2] == ofs[7:2]);
    end
  endfunction

  // ****************************************
  // Input synchronisers
  // ****************************************
  wire [NIN-1:0] raw;
  reg [NIN-1:0] sync1;
  reg [NIN-1:0] sync2;
  reg pol_d;
  reg sw_d;
  assign raw = {OTHER_FAULT_I, UNDERVOLTAGE_LOCKOUT_I, BROWNOUT_I,
                FAILSAFE_OVERVOLTAGE_SENSE_I, SWITCH_CYCLE_I, ERROR_OUT_OF_BAND_I,
                OUTPUT_SENSE_AT_95PCT_I, OUTPUT_SENSE_ABOVE_3V_I,
                OUTPUT_SENSE_DISABLED_I, LINE_POLARITY_I, LINE_SENSE_INPUT_HIGH_I,
                COMP_DISCHARGED_I, SHED_BELOW_BURST_I, COMP_ABOVE_SHED_HYS_I,
                COMP_BELOW_SHED_I, COMP_ABOVE_BURST_HYS_I, COMP_BELOW_BURST_I};

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      sync1 <= {NIN{1'b0}};
      sync2 <= {NIN{1'b0}};
      pol_d <= 1'b0;
      sw_d <= 1'b0;
    end else begin
      sync1 <= raw; // RULE21
      sync2 <= sync1; // RULE21
      pol_d <= sync2[7];
      sw_d <= sync2[12];
    end
  end

  wire below_burst = sync2[0];
  wire above_burst_hys = sync2[1];
  wire below_shed = sync2[2];
  wire above_shed_hys = sync2[3];
  wire shed_below_burst = sync2[4];
  wire comp_discharged = sync2[5];
  wire line_high = sync2[6];
  wire sense_disabled = sync2[8];
  wire sense_3v = sync2[9];
  wire sense_95 = sync2[10];
  wire err_band = sync2[11];
  wire [3:0] fault_src = {sync2[16], sync2[15], sync2[14], sync2[13]};
  wire half_cycle = sync2[7] ^ pol_d;
  wire sw_pulse = sync2[12] & ~sw_d;
  wire fault_any = sense_disabled | (|fault_src); // RULE15

  // ****************************************
  // Register file
  // ****************************************
  reg [1:0] ctrl;
  reg [7:0] filter;
  reg [4:0] fault_sticky;
  reg [2:0] state;
  reg single;
  reg [3:0] ramp;
  reg [7:0] shed_cnt;
  wire wb_req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_wr = wb_req & WB_WE_I & WB_SEL_I[0];
  wire [4:0] fault_set = {sense_disabled, fault_src};
  wire [31:0] status = {24'h000000, PHASE_B_GATE_DRIVE_ENABLE_O, GAIN_BOOST_O,
                        SOFTSTART_HI_CURRENT_O, HIGH_LINE_O, single, state};

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      ctrl <= `CTRL_RESET;
      filter <= `SHED_HALF_CYCLES;
      fault_sticky <= 5'h00;
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h00000000;
    end else begin
      WB_ACK_O <= wb_req;
      if (wb_wr && hit(WB_ADR_I, `OFS_CTRL))
        ctrl <= WB_DAT_I[1:0];
      if (wb_wr && hit(WB_ADR_I, `OFS_FILTER))
        filter <= WB_DAT_I[7:0];
      // Set wins over a write-one-to-clear in the same cycle
      if (wb_wr && hit(WB_ADR_I, `OFS_FAULT))
        fault_sticky <= (fault_sticky & ~WB_DAT_I[4:0]) | fault_set;
      else
        fault_sticky <= fault_sticky | fault_set;
      if (wb_req && !WB_WE_I) begin
        if (hit(WB_ADR_I, `OFS_CTRL))
          WB_DAT_O <= {30'h00000000, ctrl};
        else if (hit(WB_ADR_I, `OFS_FILTER))
          WB_DAT_O <= {24'h000000, filter};
        else if (hit(WB_ADR_I, `OFS_STATUS))
          WB_DAT_O <= status;
        else if (hit(WB_ADR_I, `OFS_FAULT))
          WB_DAT_O <= {27'h0000000, fault_sticky};
        else
          WB_DAT_O <= 32'h00000000;
      end
    end
  end

  // ****************************************
  // Mode state machine
  // ****************************************
  reg [2:0] next_state;
  reg [3:0] next_ramp;
  always @* begin
    next_state = state;
    next_ramp = ramp;
    // Fault first, then soft-start, then burst, then shedding
    if (fault_any) begin // RULE22
      next_state = ST_FAULT; // RULE16
      next_ramp = 4'h0;
    end else begin
      case (state)
        ST_FAULT: begin
          // A brief fault still waits for full comp discharge
          if (comp_discharged) begin // RULE16
            next_state = ST_SOFTSTART; // RULE11
            next_ramp = `RAMP_STEPS;
          end
        end
        ST_SOFTSTART: begin
          // Burst request is ignored here on purpose
          if (sense_95) // RULE13
            next_state = ST_RUN;
        end
        ST_RUN: begin
          next_ramp = `RAMP_STEPS;
          if (below_burst && ctrl[`CTRL_BURST_EN])
            next_state = ST_SOFTOFF; // RULE3
        end
        ST_SOFTOFF: begin
          if (sw_pulse) begin
            next_ramp = ramp - 4'h1; // RULE5
            if (ramp == 4'h1)
              next_state = ST_IDLE; // RULE3
          end
        end
        ST_IDLE: begin
          next_ramp = 4'h0;
          if (above_burst_hys || !ctrl[`CTRL_BURST_EN])
            next_state = ST_SOFTON; // RULE4
        end
        ST_SOFTON: begin
          if (sw_pulse) begin
            next_ramp = ramp + 4'h1; // RULE6
            if (ramp == `RAMP_STEPS - 4'h1)
              next_state = ST_RUN;
          end
        end
        default: begin
          next_state = ST_FAULT;
          next_ramp = 4'h0;
        end
      endcase
    end
  end

  // ****************************************
  // Phase shedding
  // ****************************************
  reg next_single;
  reg [7:0] next_shed_cnt;
  reg single_eff;
  always @* begin
    next_single = single;
    next_shed_cnt = shed_cnt;
    if (state != ST_RUN || !ctrl[`CTRL_SHED_EN]) begin
      next_single = 1'b0; // RULE14
      next_shed_cnt = 8'h00;
    end else if (above_shed_hys) begin
      next_single = 1'b0; // RULE20
      next_shed_cnt = 8'h00;
    end else if (!below_shed) begin
      next_shed_cnt = 8'h00; // RULE19
    end else if (half_cycle && !single) begin
      next_shed_cnt = shed_cnt + 8'h01;
      if (shed_cnt + 8'h01 >= filter)
        next_single = 1'b1; // RULE19
    end
    case (state)
      ST_RUN: single_eff = single | below_burst; // RULE7
      ST_SOFTOFF: single_eff = single | below_burst | shed_below_burst; // RULE7 RULE8
      ST_SOFTON: single_eff = single | below_burst | shed_below_burst; // RULE7 RULE8
      default: single_eff = 1'b0; // RULE14
    endcase
  end

  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      state <= ST_FAULT;
      ramp <= 4'h0;
      single <= 1'b0;
      shed_cnt <= 8'h00;
    end else begin
      state <= next_state;
      ramp <= next_ramp;
      single <= next_single;
      shed_cnt <= next_shed_cnt;
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  wire switching = (state == ST_SOFTSTART) || (state == ST_RUN) ||
                   (state == ST_SOFTOFF) || (state == ST_SOFTON);
  always @(posedge REF_CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      PHASE_A_ENABLE_O <= 1'b0;
      PHASE_B_GATE_DRIVE_ENABLE_O <= 1'b0;
      ON_TIME_DOUBLE_O <= 1'b0;
      ON_TIME_SCALE_O <= 4'h0;
      HIGH_LINE_O <= 1'b0;
      SHED_OFFSET_EN_O <= 1'b0;
      BURST_OFFSET_EN_O <= 1'b0;
      COMP_DISCHARGE_O <= 1'b1;
      STANDBY_O <= 1'b0;
      SOFTSTART_HI_CURRENT_O <= 1'b0;
      GAIN_BOOST_O <= 1'b0;
      MODE_O <= ST_FAULT;
    end else begin
      PHASE_A_ENABLE_O <= switching;
      PHASE_B_GATE_DRIVE_ENABLE_O <= switching & ~single_eff; // RULE18
      // Doubled on-time stays under the dual-phase maximum on-time clamp
      ON_TIME_DOUBLE_O <= switching & single_eff; // RULE18
      ON_TIME_SCALE_O <= (state == ST_SOFTOFF || state == ST_SOFTON) ? ramp :
                         (switching ? `RAMP_STEPS : 4'h0); // RULE5 RULE6
      HIGH_LINE_O <= line_high; // RULE1
      SHED_OFFSET_EN_O <= line_high; // RULE1
      BURST_OFFSET_EN_O <= line_high; // RULE2
      COMP_DISCHARGE_O <= (state == ST_FAULT) | fault_any; // RULE10 RULE15
      STANDBY_O <= sense_disabled; // RULE10
      SOFTSTART_HI_CURRENT_O <= (state == ST_SOFTSTART) & ~sense_3v; // RULE12
      // Boost follows the error band alone; a fault does not mask it
      GAIN_BOOST_O <= err_band; // RULE17
      MODE_O <= state;
    end
  end

endmodule // pfc_light_load_mode_sequencer

// >>> sim/pfc_seq_checker.sv
// Purpose: Port assertions for the mode sequencer
// Assumes: One clock, async active-high reset
// Notes: Levels must sit four clocks to pass the sync
`timescale 1ns/1ps
module pfc_seq_checker (
  input wire REF_CLK_I, RESET_I, WB_CYC_I, WB_STB_I, WB_ACK_O,
  input wire COMP_ABOVE_SHED_HYS_I, COMP_BELOW_BURST_I,
  input wire LINE_SENSE_INPUT_HIGH_I, ERROR_OUT_OF_BAND_I, OUTPUT_SENSE_DISABLED_I,
  input wire COMP_DISCHARGED_I, OTHER_FAULT_I, BROWNOUT_I, GAIN_BOOST_O, STANDBY_O,
  input wire PHASE_A_ENABLE_O, PHASE_B_GATE_DRIVE_ENABLE_O, ON_TIME_DOUBLE_O,
  input wire HIGH_LINE_O, SHED_OFFSET_EN_O, BURST_OFFSET_EN_O, COMP_DISCHARGE_O,
  input wire [3:0] ON_TIME_SCALE_O,
  input wire [2:0] MODE_O
);
  // ****
  // Properties
  // ****
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (RESET_I);
  sequence fault_seen; OTHER_FAULT_I || BROWNOUT_I; endsequence
  sequence undischarged; (MODE_O == 3'h0 && !COMP_DISCHARGED_I)[*4]; endsequence
  ack_pulse_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("ack not one pulse");
  line_offsets_a: assert property ($stable(LINE_SENSE_INPUT_HIGH_I)[*4] |->
    HIGH_LINE_O == LINE_SENSE_INPUT_HIGH_I && SHED_OFFSET_EN_O == HIGH_LINE_O
    && BURST_OFFSET_EN_O == HIGH_LINE_O) else $error("line range offsets wrong");
  gain_boost_a: assert property ($stable(ERROR_OUT_OF_BAND_I)[*4] |->
    GAIN_BOOST_O == ERROR_OUT_OF_BAND_I) else $error("gain boost wrong");
  standby_discharge_a: assert property (OUTPUT_SENSE_DISABLED_I[*4] |->
    STANDBY_O && COMP_DISCHARGE_O) else $error("disable not obeyed");
  fault_discharge_a: assert property (fault_seen |-> ##[2:4]
    (MODE_O == 3'h0 && COMP_DISCHARGE_O)) else $error("fault not latched");
  discharge_wait_a: assert property (undischarged |=> MODE_O == 3'h0)
    else $error("left fault before discharge");
  softstart_dual_a: assert property (MODE_O == 3'h1 |-> PHASE_A_ENABLE_O &&
    PHASE_B_GATE_DRIVE_ENABLE_O && !ON_TIME_DOUBLE_O) else $error("soft-start not dual");
  idle_stopped_a: assert property (MODE_O == 3'h4 |-> !PHASE_A_ENABLE_O &&
    ON_TIME_SCALE_O == 4'h0) else $error("idle still switching");
  ramp_down_a: assert property ((MODE_O == 3'h3)[*2] |->
    ON_TIME_SCALE_O <= $past(ON_TIME_SCALE_O)) else $error("soft-off rose");
  ramp_up_a: assert property ((MODE_O == 3'h5)[*2] |->
    ON_TIME_SCALE_O >= $past(ON_TIME_SCALE_O)) else $error("soft-on fell");
  single_phase_a: assert property (PHASE_B_GATE_DRIVE_ENABLE_O |->
    !ON_TIME_DOUBLE_O) else $error("double with phase B");
  shed_restore_a: assert property ((COMP_ABOVE_SHED_HYS_I && !COMP_BELOW_BURST_I)[*4] |=>
    MODE_O != 3'h2 || !ON_TIME_DOUBLE_O) else $error("phase B not restored");
endmodule // pfc_seq_checker
bind pfc_light_load_mode_sequencer pfc_seq_checker chk_u (.*);

// >>> sim/pfc_stage_model.sv
// Purpose: Power stage and comp node stand-in
// Assumes: Bench drives threshold comparators
// Notes: Comp recharges one step per clock, as fast as it discharges, so a fault always needs a discharge wait
`timescale 1ns/1ps
module pfc_stage_model #(
  parameter [7:0] HALF_LINE = 8'h10
) (
  input wire clk_i,
  input wire reset_i,
  input wire switching_i,
  input wire discharge_i,
  output reg switch_o,
  output reg polarity_o,
  output reg discharged_o
);
  reg [4:0] comp;
  reg [7:0] tick;
  reg [1:0] sw_cnt;
  // ****
  // Stage behaviour
  // ****
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      comp <= 5'h1f;
      tick <= 8'h00;
      sw_cnt <= 2'h0;
      switch_o <= 1'b0;
      polarity_o <= 1'b0;
      discharged_o <= 1'b0;
    end else begin
      sw_cnt <= sw_cnt + 2'h1;
      switch_o <= switching_i & sw_cnt[1];
      tick <= (tick == HALF_LINE - 8'h01) ? 8'h00 : tick + 8'h01;
      if (tick == HALF_LINE - 8'h01) begin
        polarity_o <= ~polarity_o;
      end
      if (discharge_i) begin
        comp <= comp - {4'h0, comp != 5'h00};
      end else if (comp != 5'h1f) begin
        comp <= comp + 5'h01;
      end
      discharged_o <= (comp == 5'h00);
    end
  end
endmodule // pfc_stage_model

// >>> sim/pfc_light_load_mode_sequencer_tb.sv
// Purpose: Self-checking bench for the mode sequencer
// Assumes: Stage model gives switching, line polarity, comp level
// Notes: Random filter counts and levels, fixed seed
`timescale 1ns/1ps
module pfc_light_load_mode_sequencer_tb;
  reg clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0;
  reg [7:0] adr = 8'h00;
  reg [31:0] wdat = 32'h0, q;
  reg bb = 1'b0, abh = 1'b0, bs = 1'b0, ash = 1'b0, lh = 1'b0, sd = 1'b0;
  reg sbb = 1'b0;
  reg s3 = 1'b0, s95 = 1'b0, eob = 1'b0;
  reg [3:0] flt = 4'h0, swd = 4'h0;
  wire [31:0] rd;
  wire [3:0] sc;
  wire [2:0] md;
  wire ack, sw, pol, dis, pa, pb, dbl, hl, so, bo, cd, sb, hc, gb;
  int miscompares = 0, checks_done = 0, ticks = 0, edges = 0, n, f, k;
  always #2 clk = ~clk;
  pfc_light_load_mode_sequencer dut_u (
    .REF_CLK_I(clk), .RESET_I(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rd), .WB_ACK_O(ack),
    .COMP_BELOW_BURST_I(bb), .COMP_ABOVE_BURST_HYS_I(abh), .COMP_BELOW_SHED_I(bs),
    .COMP_ABOVE_SHED_HYS_I(ash), .SHED_BELOW_BURST_I(sbb), .COMP_DISCHARGED_I(dis),
    .LINE_SENSE_INPUT_HIGH_I(lh), .LINE_POLARITY_I(pol), .OUTPUT_SENSE_DISABLED_I(sd),
    .OUTPUT_SENSE_ABOVE_3V_I(s3), .OUTPUT_SENSE_AT_95PCT_I(s95), .ERROR_OUT_OF_BAND_I(eob),
    .SWITCH_CYCLE_I(sw), .FAILSAFE_OVERVOLTAGE_SENSE_I(flt[0]), .BROWNOUT_I(flt[1]),
    .UNDERVOLTAGE_LOCKOUT_I(flt[2]), .OTHER_FAULT_I(flt[3]), .PHASE_A_ENABLE_O(pa),
    .PHASE_B_GATE_DRIVE_ENABLE_O(pb), .ON_TIME_DOUBLE_O(dbl), .ON_TIME_SCALE_O(sc),
    .HIGH_LINE_O(hl), .SHED_OFFSET_EN_O(so), .BURST_OFFSET_EN_O(bo), .COMP_DISCHARGE_O(cd),
    .STANDBY_O(sb), .SOFTSTART_HI_CURRENT_O(hc), .GAIN_BOOST_O(gb), .MODE_O(md));
  pfc_stage_model #(.HALF_LINE(8'h10)) stage_u (.clk_i(clk), .reset_i(rst),
    .switching_i(pa), .discharge_i(cd), .switch_o(sw), .polarity_o(pol), .discharged_o(dis));
  // ****
  // Tasks
  // ****
  task chk(input [31:0] got, input [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb(input w, input [7:0] a, input [31:0] d, output [31:0] r);
    @(posedge clk);
    cyc <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    r = rd;
    cyc <= 1'b0; we <= 1'b0;
  endtask
  task wm(input [2:0] m);
    n = 0;
    while (md !== m && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(md, m);
  endtask
  // Switch edges reach the state machine three clocks late
  always @(posedge clk) begin
    swd <= {swd[2:0], sw};
    if (swd[2] && !swd[3] && (md == 3'h3 || md == 3'h5)) edges++;
    ticks++;
    if (ticks == 20000) begin
      miscompares++;
      print_verdict;
    end
  end
  task ramp(input [2:0] m);
    edges = 0;
    wm(m);
    while (md === m) begin
      if (sbb) chk(dbl, 1'b1);
      @(posedge clk);
    end
    chk(edges, 8);
  endtask
  task print_verdict;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****
  // Tests
  // ****
  initial begin
    void'($urandom(32'h2c1d));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, 8'h00, 0, q); chk(q, 32'h3);
    wb(1'b0, 8'h04, 0, q); chk(q, 32'h0e);
    wb(1'b0, 8'h10, 0, q); chk(q, 32'h0);
    wm(3'h1); chk(hc, 1'b1);
    bb <= 1'b1; s3 <= 1'b1;
    repeat (8) @(posedge clk);
    chk(hc, 1'b0); chk(md, 3'h1); chk(pb, 1'b1);
    bb <= 1'b0; s95 <= 1'b1;
    wm(3'h2); $display("test softstart done");
    for (k = 0; k < 6; k++) begin
      {lh, eob} <= 2'($urandom);
      repeat (6) @(posedge clk);
      chk({hl, so, bo}, {lh, lh, lh}); chk(gb, eob);
    end
    wb(1'b0, 8'h08, 0, q); chk(q[4], lh); $display("test range done");
    f = 4 + $urandom % 8;
    wb(1'b1, 8'h04, f, q); bs <= 1'b1;
    repeat ((f - 2) * 16) @(posedge clk);
    chk(dbl, 1'b0);
    repeat (64) @(posedge clk);
    chk({dbl, pb}, 2'b10);
    bs <= 1'b0; ash <= 1'b1;
    repeat (5) @(posedge clk);
    chk({dbl, pb}, 2'b01); $display("test shed done");
    ash <= 1'b0;
    wb(1'b1, 8'h00, 2, q); bb <= 1'b1;
    repeat (5) @(posedge clk);
    chk({dbl, md}, 4'ha);
    bb <= 1'b0; wb(1'b1, 8'h00, 3, q);
    sbb <= 1'b1; bb <= 1'b1;
    ramp(3'h3); chk({pa, md}, 4'h4);
    bb <= 1'b0; abh <= 1'b1;
    ramp(3'h5); chk({sc, md}, 7'h42); $display("test burst done");
    abh <= 1'b0; sbb <= 1'b0;
    for (k = 0; k < 5; k++) begin
      if (k < 4) begin
        flt[k] <= 1'b1;
        @(posedge clk);
        flt <= 4'h0;
      end else begin
        sd <= 1'b1;
        repeat (6) @(posedge clk);
        chk(sb, 1'b1); sd <= 1'b0;
      end
      wm(3'h0); chk(cd, 1'b1);
      wb(1'b0, 8'h0c, 0, q); chk(q, 32'h1 << k);
      wb(1'b1, 8'h0c, 32'h1f, q); wm(3'h1); wm(3'h2);
    end
    $display("test fault done");
    print_verdict;
  end
endmodule // pfc_light_load_mode_sequencer_tb
